// file: design/dbus_pkg.sv
// Shared constants and carrier types for the core data bus interface.
// Assumes one clock; memory side qualifies every bus cycle with its enable.
package dbus_pkg;

  // ----------------------------------------------------------------
  // Widths and limits
  // ----------------------------------------------------------------
  localparam int unsigned DATA_W     = 32;
  localparam int unsigned FIFO_DEPTH = 4;
  localparam int unsigned CNT_W      = 3;
  localparam logic [3:0]  FIFO_LIMIT = 4'h4;
  localparam logic [31:0] WORD_STEP  = 32'h4;
  localparam logic [3:0]  BURST_ONE  = 4'h0;
  localparam logic [31:0] ADDR_RST   = 32'h0;
  localparam logic [31:0] DATA_RST   = 32'h0;

  // ----------------------------------------------------------------
  // Access size and cycle-type codes
  // ----------------------------------------------------------------
  localparam logic [1:0] SIZE_BYTE = 2'h0;
  localparam logic [1:0] SIZE_HALF = 2'h1;
  localparam logic [1:0] SIZE_WORD = 2'h2;
  // {data_request_low, data_sequential}
  localparam logic [1:0] CYC_N = 2'h0;
  localparam logic [1:0] CYC_S = 2'h1;
  localparam logic [1:0] CYC_I = 2'h2;
  localparam logic [1:0] CYC_C = 2'h3;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    OP_LOAD,
    OP_STORE,
    OP_SWAP,
    OP_CP_MEM,
    OP_CP_REG
  } op_t;

  typedef enum logic [1:0] {
    SEQ_IDLE,
    SEQ_RUN,
    SEQ_SWAP_WR
  } seq_state_t;

  typedef struct packed {
    op_t         op;
    logic        write;
    logic [1:0]  size;
    logic        priv;
    logic [3:0]  words_m1;
    logic [31:0] addr;
  } cmd_t;

  typedef struct packed {
    logic        req_low;
    logic        seq;
    logic        more;
    logic [3:0]  burst;
    logic [31:0] addr;
    logic [1:0]  size;
    logic        write;
    logic        priv;
  } addr_phase_t;

endpackage : dbus_pkg

// file: design/dbus_fifo.sv
// Small synchronous FIFO with valid/ready on both sides and a fill count.
// Assumes single clock, synchronous active-low reset.
`timescale 1ns/1ps
`default_nettype none
module dbus_fifo #(
  parameter int unsigned WIDTH = 32,
  parameter int unsigned DEPTH = 4
) (
  // Clock and reset
  input  wire logic                         i_clk,
  input  wire logic                         i_rst_n,
  // Fill side
  input  wire logic                         i_in_valid,
  output logic                              o_in_ready,
  input  wire logic [WIDTH-1:0]             i_in_data,
  // Drain side
  output logic                              o_out_valid,
  input  wire logic                         i_out_ready,
  output logic [WIDTH-1:0]                  o_out_data,
  output logic [$clog2(DEPTH+1)-1:0]        o_count
);
  localparam int unsigned PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int unsigned CW = $clog2(DEPTH+1);

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [PW-1:0]               wp;
    logic [PW-1:0]               rp;
    logic [CW-1:0]               cnt;
  } fifo_st_t;

  fifo_st_t st_q;
  fifo_st_t st_d;
  logic     push;
  logic     pop;

  assign o_in_ready  = st_q.cnt != CW'(DEPTH);
  assign o_out_valid = st_q.cnt != '0;
  assign o_out_data  = st_q.mem[st_q.rp];
  assign o_count     = st_q.cnt;

  always_comb begin
    st_d = st_q;
    push = i_in_valid && o_in_ready;
    pop  = i_out_ready && o_out_valid;
    if (push) begin
      st_d.mem[st_q.wp] = i_in_data;
      st_d.wp = (st_q.wp == PW'(DEPTH-1)) ? '0 : st_q.wp + PW'(1);
    end
    if (pop) begin
      st_d.rp = (st_q.rp == PW'(DEPTH-1)) ? '0 : st_q.rp + PW'(1);
    end
    st_d.cnt = st_q.cnt + CW'(push) - CW'(pop);
  end

  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

endmodule : dbus_fifo
`default_nettype wire

// file: design/dbus_core_if.sv
// Data-side bus interface of the core: turns load/store commands into
// pipelined request, address and data cycles, with a read-data FIFO.
// Assumes memory side is synchronous to i_clk and waits by bus enable.
//
// Contract
// - Request and address go out one bus cycle before their data.
// - Back-to-back N cycles allowed; slow memory stretches with the enable.
// - First beat may reuse internal-cycle address; later beats add 4.
// - Only word accesses form bursts; no halfword or byte bursts.
// - Burst is N then S beats sharing width, direction, protection.
// - More-follows only in multiples, only with request, one cycle ahead.
// - Burst length shown with request in the first cycle.
// - Burst length is words minus one; zero means one or unknown.
// - Coprocessor and swap accesses drive burst length zero.
// - Cancel only the cycle after a request; changes only on enabled edges.
// - Abort on previous instruction cancels the next instruction's access.
// - Halfword writes duplicated twice, bytes four times across the bus.
// - Endian select affects only sub-word reads; lanes from size, address.
// - Request-low/sequential: 00 N, 01 S, 10 I, 11 C.
// - Size codes byte 00, half 01, word 10; low address bits ignored.
// - Little-endian low lanes first; big-endian reverses lane choice.
`timescale 1ns/1ps
`default_nettype none
module dbus_core_if (
  // Clock and reset
  input  wire logic                      i_clk,
  input  wire logic                      i_rst_n,
  // Memory side inputs
  input  wire logic                      i_bus_cycle_enable,
  input  wire logic                      i_data_abort_input,
  input  wire logic [31:0]               i_rdata,
  input  wire logic                      i_endian_select,
  // Memory side outputs
  output logic                           o_data_request_low,
  output logic                           o_data_sequential,
  output logic                           o_data_more_follows,
  output logic [3:0]                     o_data_burst_length,
  output logic [31:0]                    o_data_address_bus,
  output logic [1:0]                     o_data_access_size,
  output logic                           o_data_write,
  output logic                           o_data_priv,
  output logic                           o_data_access_cancel,
  output logic [31:0]                    o_wdata,
  // Command side
  input  wire logic                      i_cmd_valid,
  input  wire dbus_pkg::cmd_t            i_cmd,
  output logic                           o_cmd_ready,
  // Write data side
  input  wire logic                      i_wr_valid,
  input  wire logic [31:0]               i_wr_data,
  output logic                           o_wr_ready,
  // Read data side
  output logic                           o_rd_valid,
  output logic [31:0]                    o_rd_data,
  input  wire logic                      i_rd_ready,
  // Status
  output logic                           o_abort
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    dbus_pkg::seq_state_t  sst;
    dbus_pkg::cmd_t        cmd;
    logic                  first;
    logic [3:0]            remain;
    logic [31:0]           next_addr;
    logic                  id;
    dbus_pkg::addr_phase_t ap;
    dbus_pkg::op_t         ap_op;
    logic [31:0]           ap_wdata;
    logic                  ap_id;
    logic                  dp_mem;
    logic                  dp_rd;
    logic                  dp_wr;
    logic [1:0]            dp_size;
    logic [1:0]            dp_a10;
    logic [31:0]           dp_wdata;
    logic                  dp_id;
    logic                  cancel;
    logic                  abort;
  } st_t;

  st_t                          st_q;
  st_t                          st_d;
  logic                         abort_now;
  logic                         push;
  logic                         wr_beat;
  logic                         go;
  logic                         cp;
  logic                         more;
  logic                         room;
  logic                         room2;
  logic                         ap_act;
  logic [3:0]                   need;
  logic [31:0]                  rd_lane;
  logic                         fifo_in_ready;
  logic [dbus_pkg::CNT_W-1:0]   fifo_count;

  // ----------------------------------------------------------------
  // Lane helpers
  // ----------------------------------------------------------------
  function automatic logic [31:0] replicate(input logic [1:0] size, input logic [31:0] w);
    case (size)
      dbus_pkg::SIZE_HALF: replicate = {2{w[15:0]}};
      dbus_pkg::SIZE_BYTE: replicate = {4{w[7:0]}};
      default:             replicate = w;
    endcase
  endfunction : replicate

  // Word returned whole; only the addressed lanes are kept
  function automatic logic [31:0] extract(input logic [1:0] size, input logic [1:0] a10,
                                          input logic big, input logic [31:0] w);
    logic [1:0] idx;
    idx = big ? ~a10 : a10;
    case (size)
      dbus_pkg::SIZE_HALF: extract = {16'h0, (a10[1] ^ big) ? w[31:16] : w[15:0]};
      dbus_pkg::SIZE_BYTE: extract = {24'h0, w[8*idx +: 8]};
      default:             extract = w;
    endcase
  endfunction : extract

  // ----------------------------------------------------------------
  // Read data FIFO
  // ----------------------------------------------------------------
  assign rd_lane = extract(st_q.dp_size, st_q.dp_a10, i_endian_select, i_rdata);

  dbus_fifo #(
    .WIDTH (dbus_pkg::DATA_W),
    .DEPTH (dbus_pkg::FIFO_DEPTH)
  ) u_rd_fifo (
    .i_clk       (i_clk),
    .i_rst_n     (i_rst_n),
    .i_in_valid  (push),
    .o_in_ready  (fifo_in_ready),
    .i_in_data   (rd_lane),
    .o_out_valid (o_rd_valid),
    .i_out_ready (i_rd_ready),
    .o_out_data  (o_rd_data),
    .o_count     (fifo_count)
  );

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    st_d      = st_q;
    st_d.abort = 1'b0;
    abort_now = st_q.dp_mem && !st_q.cancel && i_data_abort_input;
    // Data phase ends only on an enabled edge
    push      = i_bus_cycle_enable && st_q.dp_rd && !st_q.cancel;
    wr_beat   = (st_q.sst == dbus_pkg::SEQ_SWAP_WR) ||
                (st_q.sst == dbus_pkg::SEQ_RUN && st_q.cmd.write);
    // Reads reserve a FIFO slot before they go out, so drain stalls issue
    need      = 4'(fifo_count) + 4'(st_q.dp_rd) + 4'h1 +
                4'(!st_q.ap.write && (!st_q.ap.req_low || st_q.ap.seq));
    room      = need <= dbus_pkg::FIFO_LIMIT;
    room2     = (need + 4'h1) <= dbus_pkg::FIFO_LIMIT;
    go        = (st_q.sst != dbus_pkg::SEQ_IDLE) && !abort_now &&
                (wr_beat ? i_wr_valid : (room && fifo_in_ready));
    cp        = st_q.cmd.op == dbus_pkg::OP_CP_REG;
    // A later beat is promised only when its slot is already guaranteed
    more      = !cp && (st_q.remain != 4'h0) && (wr_beat || room2);
    ap_act    = !st_q.ap.req_low || st_q.ap.seq;
    o_cmd_ready = (st_q.sst == dbus_pkg::SEQ_IDLE) && !(i_bus_cycle_enable && abort_now);
    o_wr_ready  = i_bus_cycle_enable && go && wr_beat;

    if (i_cmd_valid && o_cmd_ready) begin
      st_d.cmd       = i_cmd;
      st_d.sst       = dbus_pkg::SEQ_RUN;
      st_d.first     = 1'b1;
      st_d.next_addr = i_cmd.addr;
      st_d.id        = !st_q.id;
      st_d.remain    = 4'h0;
      if ((i_cmd.op == dbus_pkg::OP_LOAD) || (i_cmd.op == dbus_pkg::OP_STORE) ||
          (i_cmd.op == dbus_pkg::OP_CP_MEM)) begin
        st_d.remain = i_cmd.words_m1;
      end
      if (i_cmd.words_m1 != 4'h0 && i_cmd.op != dbus_pkg::OP_SWAP &&
          i_cmd.op != dbus_pkg::OP_CP_REG) begin
        st_d.cmd.size = dbus_pkg::SIZE_WORD;
      end
    end

    if (i_bus_cycle_enable) begin
      st_d.abort    = abort_now;
      // Address phase moves to data phase one bus cycle later
      st_d.dp_mem   = !st_q.ap.req_low;
      st_d.dp_rd    = ap_act && !st_q.ap.write;
      st_d.dp_wr    = ap_act && st_q.ap.write;
      st_d.dp_size  = st_q.ap.size;
      st_d.dp_a10   = st_q.ap.addr[1:0];
      st_d.dp_wdata = st_q.ap_wdata;
      st_d.dp_id    = st_q.ap_id;
      // Kill the next instruction's request after an abort
      st_d.cancel   = abort_now && !st_q.ap.req_low && (st_q.ap_id != st_q.dp_id);
      // Idle default: internal cycle, address parked on the next beat
      st_d.ap.req_low = 1'b1;
      st_d.ap.seq     = 1'b0;
      st_d.ap.more    = 1'b0;
      st_d.ap.burst   = dbus_pkg::BURST_ONE;
      st_d.ap.addr    = st_q.next_addr;
      if (abort_now) begin
        st_d.sst = dbus_pkg::SEQ_IDLE;
      end else if (go) begin
        // N cycles may follow each other directly
        st_d.ap.req_low = cp;
        st_d.ap.seq     = cp || !st_q.first;
        st_d.ap.more    = more;
        st_d.ap.size    = st_q.cmd.size;
        st_d.ap.write   = wr_beat;
        st_d.ap.priv    = st_q.cmd.priv;
        st_d.ap.burst   = dbus_pkg::BURST_ONE;
        if (st_q.first && (st_q.cmd.op == dbus_pkg::OP_LOAD ||
                           st_q.cmd.op == dbus_pkg::OP_STORE)) begin
          st_d.ap.burst = st_q.remain;
        end
        st_d.ap_op    = st_q.cmd.op;
        st_d.ap_id    = st_q.id;
        st_d.ap_wdata = wr_beat ? replicate(st_q.cmd.size, i_wr_data) : dbus_pkg::DATA_RST;
        st_d.first    = !more;
        if (st_q.remain != 4'h0) begin
          st_d.remain    = st_q.remain - 4'h1;
          st_d.next_addr = st_q.next_addr + dbus_pkg::WORD_STEP;
        end else if (st_q.cmd.op == dbus_pkg::OP_SWAP && st_q.sst == dbus_pkg::SEQ_RUN) begin
          st_d.sst   = dbus_pkg::SEQ_SWAP_WR;
          st_d.first = 1'b1;
        end else begin
          st_d.sst = dbus_pkg::SEQ_IDLE;
        end
      end else if (st_q.sst != dbus_pkg::SEQ_IDLE) begin
        // After a stall the rest restarts as a fresh burst
        st_d.first = 1'b1;
      end
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      st_q              <= '0;
      st_q.sst          <= dbus_pkg::SEQ_IDLE;
      st_q.ap.req_low   <= 1'b1;
      st_q.ap.size      <= dbus_pkg::SIZE_WORD;
      st_q.ap.addr      <= dbus_pkg::ADDR_RST;
      st_q.first        <= 1'b1;
    end else begin
      st_q <= st_d;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign o_data_request_low   = st_q.ap.req_low;
  assign o_data_sequential    = st_q.ap.seq;
  assign o_data_more_follows  = st_q.ap.more;
  assign o_data_burst_length  = st_q.ap.burst;
  assign o_data_address_bus   = st_q.ap.addr;
  assign o_data_access_size   = st_q.ap.size;
  assign o_data_write         = st_q.ap.write;
  assign o_data_priv          = st_q.ap.priv;
  assign o_data_access_cancel = st_q.cancel;
  assign o_wdata              = st_q.dp_wdata;
  assign o_abort              = st_q.abort;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);

  cancel_hold_a: assert property (
    !i_bus_cycle_enable |=> $stable(o_data_access_cancel) && $stable(o_data_request_low))
    else $error("cancel or request moved without bus enable");

  cancel_after_req_a: assert property (
    $rose(o_data_access_cancel) |-> $past(!o_data_request_low) && $past(i_bus_cycle_enable))
    else $error("cancel without a request one cycle earlier");

  more_with_req_a: assert property (
    o_data_more_follows |-> !o_data_request_low && !o_data_sequential ||
                            !o_data_request_low)
    else $error("more-follows high without a request");

  more_then_seq_a: assert property (
    o_data_more_follows && i_bus_cycle_enable && !i_data_abort_input |=>
      !o_data_request_low && o_data_sequential)
    else $error("more-follows not followed by a sequential beat");

  seq_addr_step_a: assert property (
    o_data_more_follows && i_bus_cycle_enable && !i_data_abort_input |=>
      o_data_address_bus == $past(o_data_address_bus) + dbus_pkg::WORD_STEP)
    else $error("burst address did not advance by one word");

  burst_same_a: assert property (
    o_data_more_follows && i_bus_cycle_enable && !i_data_abort_input |=>
      $stable(o_data_write) && $stable(o_data_priv) && $stable(o_data_access_size))
    else $error("burst beats differ in type");

  burst_word_a: assert property (
    !o_data_request_low && (o_data_sequential || o_data_more_follows) |->
      o_data_access_size == dbus_pkg::SIZE_WORD)
    else $error("sub-word access in a burst");

  burst_first_a: assert property (
    o_data_burst_length != dbus_pkg::BURST_ONE |-> !o_data_request_low && !o_data_sequential)
    else $error("burst length outside the first cycle");

  burst_zero_a: assert property (
    st_q.ap_op inside {dbus_pkg::OP_SWAP, dbus_pkg::OP_CP_MEM, dbus_pkg::OP_CP_REG} |->
      o_data_burst_length == dbus_pkg::BURST_ONE)
    else $error("swap or coprocessor access with nonzero burst length");

  pipe_data_a: assert property (
    i_bus_cycle_enable && !o_data_request_low |=>
      st_q.dp_mem && st_q.dp_size == $past(o_data_access_size))
    else $error("request did not reach the data phase");

  abort_kill_a: assert property (
    i_bus_cycle_enable && i_data_abort_input && st_q.dp_mem && !o_data_access_cancel &&
    !o_data_request_low && st_q.ap_id != st_q.dp_id |=> o_data_access_cancel)
    else $error("abort did not cancel the next access");

  lane_copy_a: assert property (
    st_q.dp_wr && st_q.dp_size != dbus_pkg::SIZE_WORD |->
      o_wdata[31:16] == o_wdata[15:0] &&
      (st_q.dp_size != dbus_pkg::SIZE_BYTE || o_wdata[15:8] == o_wdata[7:0]))
    else $error("write data not replicated across lanes");

  burst3_c:  cover property (o_data_more_follows ##1 o_data_more_follows ##1 o_data_sequential);
  cancel_c:  cover property (o_data_access_cancel);
  cp_xfer_c: cover property ({o_data_request_low, o_data_sequential} == dbus_pkg::CYC_C);
  fifo_full_c: cover property (!fifo_in_ready);

endmodule : dbus_core_if
`default_nettype wire

// file: dv/mem_ctrl_model.sv
// Memory controller model answering the core data bus.
// Assumes one clock, synchronous active-low reset; the bench steers stretch and abort.
`timescale 1ns/1ps
`default_nettype none
module mem_ctrl_model (
  // Clock and reset
  input  wire logic        i_clk,
  input  wire logic        i_rst_n,
  // Core address phase
  input  wire logic        i_req_low,
  input  wire logic        i_write,
  input  wire logic [31:0] i_addr,
  input  wire logic        i_cancel,
  input  wire logic        i_seq,
  input  wire logic [3:0]  i_burst,
  // Bench steering
  input  wire logic        i_slow,
  input  wire logic        i_abort_next,
  // Answers
  output logic             o_enable,
  output logic             o_abort,
  output logic [31:0]      o_rdata,
  output logic [31:0]      o_commits,
  output logic [3:0]       o_beats_left
);
  logic rd_q;
  logic wr_q;
  always @(posedge i_clk) begin
    if (!i_rst_n) begin
      {rd_q, wr_q, o_abort} <= 3'h0;
      o_enable  <= 1'b1;
      o_rdata   <= 32'h0;
      o_commits <= 32'h0;
      o_beats_left <= 4'h0;
    end else begin
      o_enable <= !i_slow || ($urandom_range(2) == 0);
      if (o_enable) begin
        // Commit only uncancelled N/S writes
        if (wr_q && !i_cancel) o_commits <= o_commits + 32'h1;
        wr_q    <= !i_req_low && i_write;
        rd_q    <= !i_req_low && !i_write;
        o_abort <= !i_req_low && i_abort_next;
        // Length held from the N beat; a cancel throws it away
        if (!i_req_low) o_beats_left <= i_seq ? o_beats_left - 4'h1 : i_burst;
        else if (i_cancel) o_beats_left <= 4'h0;
        // Full word always returned; released bus toggles
        o_rdata <= !i_req_low ? ({i_addr[31:2], 2'h0} ^ 32'h5a3c_96e1) : ~o_rdata;
      end else if (!rd_q) o_rdata <= ~o_rdata;
    end
  end
endmodule : mem_ctrl_model
`default_nettype wire

// file: dv/tb.sv
// Self-checking bench for the core data bus interface.
// Assumes the design package, FIFO, core interface and memory model compile first.
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic i_clk, i_rst_n, i_cmd_valid, i_wr_valid, i_rd_ready, i_endian_select, slow, abort_next;
  logic en, abort_in, d_req, d_seq, d_more, d_wr, cancel, cmd_rdy, wr_rdy, rd_vld, abort_o;
  logic pv_wr, pv_mem, pv_more, first_n, seen, w, d_priv;
  logic [31:0] i_wr_data, rdata, commits, pv_addr, d_addr, wdata, rd_data, a;
  logic [3:0] d_burst, exp_burst, n, beats_left;
  logic [1:0] d_size, sz;
  dbus_pkg::cmd_t i_cmd;
  dbus_pkg::op_t op;
  logic [31:0] wq[$], wexp[$], rexp[$];
  int err_total, n_checks, n_wr, k;

  initial begin
    i_clk = 1'b0;
    forever #10 i_clk = ~i_clk;
  end

  dbus_core_if DUT (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_bus_cycle_enable(en),
    .i_data_abort_input(abort_in), .i_rdata(rdata), .i_endian_select(i_endian_select),
    .o_data_request_low(d_req), .o_data_sequential(d_seq), .o_data_more_follows(d_more),
    .o_data_burst_length(d_burst), .o_data_address_bus(d_addr), .o_data_access_size(d_size),
    .o_data_write(d_wr), .o_data_priv(d_priv), .o_data_access_cancel(cancel), .o_wdata(wdata),
    .i_cmd_valid(i_cmd_valid), .i_cmd(i_cmd), .o_cmd_ready(cmd_rdy), .i_wr_valid(i_wr_valid),
    .i_wr_data(i_wr_data), .o_wr_ready(wr_rdy), .o_rd_valid(rd_vld), .o_rd_data(rd_data),
    .i_rd_ready(i_rd_ready), .o_abort(abort_o));

  mem_ctrl_model mem (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_req_low(d_req), .i_write(d_wr),
    .i_addr(d_addr), .i_cancel(cancel), .i_seq(d_seq), .i_burst(d_burst), .i_slow(slow),
    .i_abort_next(abort_next), .o_enable(en), .o_abort(abort_in), .o_rdata(rdata),
    .o_commits(commits), .o_beats_left(beats_left));

  // ----------------------------------------------------------------
  // Expectations and checks
  // ----------------------------------------------------------------
  function automatic logic [31:0] lane(input logic [31:0] x, input logic [1:0] s,
                                       input logic [1:0] l, input logic big);
    logic [1:0] b;
    b = big ? ~l : l;
    if (s == dbus_pkg::SIZE_WORD) return x;
    if (s == dbus_pkg::SIZE_HALF) return {16'h0, x[16*b[1] +: 16]};
    return {24'h0, x[8*b +: 8]};
  endfunction : lane

  function automatic logic [31:0] rep(input logic [31:0] x, input logic [1:0] s);
    if (s == dbus_pkg::SIZE_WORD) return x;
    if (s == dbus_pkg::SIZE_HALF) return {2{x[15:0]}};
    return {4{x[7:0]}};
  endfunction : rep

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      err_total++;
      $display("wrong value at %0t: got %h, expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic wrap_up;
    $display("checks %0d, mismatches %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : wrap_up

  task automatic issue(input dbus_pkg::op_t o, input logic wr, input logic [1:0] s,
                       input logic [3:0] m, input logic [31:0] ad, input logic big);
    int t;
    logic [31:0] d;
    i_endian_select <= big;
    for (t = 0; t <= int'(m); t++) begin
      d = $urandom();
      if (wr) begin
        wq.push_back(d);
        wexp.push_back(rep(d, s));
        n_wr += int'(o != dbus_pkg::OP_CP_REG);
      end
      if (!wr || o == dbus_pkg::OP_SWAP)
        rexp.push_back(lane({ad[31:2] + 30'(t), 2'h0} ^ 32'h5a3c_96e1, s, ad[1:0], big));
    end
    i_cmd <= '{op: o, write: wr && o != dbus_pkg::OP_SWAP, size: s, priv: 1'($urandom()),
               words_m1: m, addr: ad};
    exp_burst <= (o == dbus_pkg::OP_LOAD || o == dbus_pkg::OP_STORE) ? m : 4'h0;
    i_cmd_valid <= 1'b1;
    for (t = 0; t < 300; t++) begin
      @(posedge i_clk);
      if (cmd_rdy === 1'b1) break;
    end
    if (t == 300) begin
      chk(32'h0, 32'h1);
      wrap_up();
    end
    i_cmd_valid <= 1'b0;
    first_n <= 1'b1;
    for (t = 0; t < 3000; t++) begin
      @(posedge i_clk);
      if (rexp.size() == 0 && wexp.size() == 0 && cmd_rdy === 1'b1) break;
    end
    if (t == 3000) begin
      chk(32'h0, 32'h1);
      wrap_up();
    end
  endtask : issue

  // ----------------------------------------------------------------
  // Write feed, read drain and bus monitor
  // ----------------------------------------------------------------
  always @(posedge i_clk) begin
    if (wr_rdy === 1'b1 && en && wq.size() > 0) void'(wq.pop_front());
    i_wr_valid <= wq.size() > 0;
    i_wr_data <= wq.size() > 0 ? wq[0] : 32'h0;
    i_rd_ready <= $urandom_range(3) != 0;
    if (abort_o === 1'b1) seen <= 1'b1;
    if (i_rst_n && rd_vld === 1'b1 && i_rd_ready)
      chk(rd_data, rexp.size() > 0 ? rexp.pop_front() : ~rd_data);
  end

  always @(posedge i_clk) begin
    if (!i_rst_n) begin
      {pv_wr, pv_mem, pv_more} <= 3'h0;
    end else if (en) begin
      if (pv_mem && pv_wr && cancel !== 1'b1)
        chk(wdata, wexp.size() > 0 ? wexp.pop_front() : ~wdata);
      if ({d_req, d_seq} === dbus_pkg::CYC_S) begin
        chk(d_addr, pv_addr + dbus_pkg::WORD_STEP);
        chk({29'h0, d_wr, d_size}, {29'h0, pv_wr, dbus_pkg::SIZE_WORD});
        chk({31'h0, beats_left != 4'h0}, 32'h1);
      end
      if (pv_more) chk({30'h0, d_req, d_seq}, {30'h0, dbus_pkg::CYC_S});
      if (first_n && d_req === 1'b0) begin
        chk({27'h0, d_priv, d_burst}, {27'h0, i_cmd.priv, exp_burst});
        first_n <= 1'b0;
      end
      pv_mem <= d_req === 1'b0 || d_seq === 1'b1;
      pv_wr <= d_wr;
      pv_more <= d_more;
      pv_addr <= d_addr;
    end
  end

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    {i_rst_n, i_cmd_valid, i_wr_valid, i_endian_select, slow, abort_next, first_n, seen} = 8'h0;
    i_rd_ready = 1'b1;
    i_cmd = '0;
    i_wr_data = 32'h0;
    exp_burst = 4'h0;
    {err_total, n_checks, n_wr} = 0;
    void'($urandom(32'heb42));
    repeat (20) @(posedge i_clk);
    i_rst_n <= 1'b1;
    @(posedge i_clk);
    issue(dbus_pkg::OP_LOAD, 1'b0, dbus_pkg::SIZE_WORD, 4'hf, 32'h100, 1'b0);
    issue(dbus_pkg::OP_STORE, 1'b1, dbus_pkg::SIZE_WORD, 4'hf, 32'h200, 1'b0);
    for (k = 0; k < 16; k++)
      issue(dbus_pkg::OP_LOAD, 1'b0, k[3] ? dbus_pkg::SIZE_HALF : dbus_pkg::SIZE_BYTE, 4'h0,
            {28'h3, k[1:0], 2'h0} | 32'(k[1:0]), k[2]);
    for (k = 0; k < 40; k++) begin
      sz = 2'($urandom_range(2));
      w = 1'($urandom());
      op = k % 7 == 1 ? dbus_pkg::OP_CP_REG : k % 7 == 3 ? dbus_pkg::OP_SWAP :
           k % 7 == 5 ? dbus_pkg::OP_CP_MEM : w ? dbus_pkg::OP_STORE : dbus_pkg::OP_LOAD;
      n = (sz == dbus_pkg::SIZE_WORD && !(k % 7 inside {1, 3, 5})) ? 4'($urandom()) : 4'h0;
      a = {$urandom_range(32'hffff) << 4} | (sz == dbus_pkg::SIZE_WORD ? 32'h0 : 32'($urandom_range(3)));
      slow <= 1'($urandom());
      issue(op, w || op inside {dbus_pkg::OP_SWAP, dbus_pkg::OP_CP_REG}, sz, n, a,
            1'($urandom()));
    end
    // Aborted read still lands in the FIFO; only a cancel drops it
    slow <= 1'b0;
    abort_next <= 1'b1;
    issue(dbus_pkg::OP_LOAD, 1'b0, dbus_pkg::SIZE_WORD, 4'h0, 32'h400, 1'b0);
    @(posedge i_clk);
    abort_next <= 1'b0;
    chk({31'h0, seen}, 32'h1);
    issue(dbus_pkg::OP_LOAD, 1'b0, dbus_pkg::SIZE_WORD, 4'h0, 32'h500, 1'b0);
    @(posedge i_clk);
    chk(commits, 32'(n_wr));
    wrap_up();
  end
endmodule : tb
`default_nettype wire
